// ---- rtl/bus_status_pkg.sv ----
// constants for the bus event status half-dword
package bus_status_pkg;
   // configuration dword that holds the status half (byte offset 04h)
   localparam logic [5:0] STATUS_DWORD = 6'h01;
   // field positions within the 16-bit status half (bit n here is dword bit n+16)
   localparam int DPE_BIT = 15;
   localparam int SSE_BIT = 14;
   localparam int RMA_BIT = 13;
   localparam int RTA_BIT = 12;
   localparam int STA_BIT = 11;
   localparam int DEVSEL_LSB = 9;
   localparam int MDPE_BIT = 8;
   localparam int FBB_BIT = 7;
   localparam int CAPL_BIT = 4;
   // fixed field values
   localparam logic [1:0] DEVSEL_FAST = 2'h0;
   localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
   localparam logic [1:0] DEVSEL_SLOW = 2'h2;
   localparam logic FBB_VALUE = 1'b1;
   localparam logic STA_VALUE = 1'b0;
   // reset values
   localparam logic STICKY_RESET = 1'b0;
   localparam logic [15:0] RDATA_RESET = 16'h0000;
   localparam logic PIN_IDLE = 1'b1;
   // first capabilities list entry in configuration space
   localparam logic [7:0] CAP_PTR_OFFSET = 8'hDC;
   localparam logic [7:0] CAP_PTR_NONE = 8'h00;
   // driver states for the system error pin
   typedef enum logic [0:0] {SERR_IDLE, SERR_DRIVE} serr_state_t;
endpackage

// ---- rtl/pin_filter.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_filter
   import bus_status_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic pin_in,
   output logic level_q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // first stage is read only by the second
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= PIN_IDLE;
         s2_q <= PIN_IDLE;
         s3_q <= PIN_IDLE;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a change counts only once two late stages agree
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         level_q <= PIN_IDLE;
      end else if (s2_q == s3_q) begin
         level_q <= s3_q;
      end
   end
endmodule

// ---- rtl/bus_status_regs.sv ----
// bus event status half of configuration dword 04h
`timescale 1ns/1ps
module bus_status_regs
   import bus_status_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [5:0] cfg_dw_addr,
   input wire logic [3:2] cfg_be_n,
   input wire logic [31:16] cfg_wdata,
   input wire logic cmd_perr_resp,
   input wire logic cmd_serr_en,
   input wire logic parity_err_det,
   input wire logic serr_req,
   input wire logic master_abort,
   input wire logic target_abort_rcvd,
   input wire logic perr_self,
   input wire logic master_of_op,
   input wire logic perr_n_in,
   input wire logic eeprom_pm_en,
   output logic [15:0] cfg_rdata_q,
   output logic [7:0] cap_ptr_q,
   output logic cap_list_q,
   output logic serr_n_o_q,
   output logic serr_oe_n_q
);
   logic dpe_q;
   logic sse_q;
   logic rma_q;
   logic rta_q;
   logic mdpe_q;
   logic perr_lvl;
   logic perr_prev_q;
   logic perr_seen;
   logic status_sel;
   logic [15:0] clr_mask;
   logic serr_fire;
   logic mdpe_set;
   logic [15:0] status_word;
   serr_state_t serr_state_q;

   // byte lane 3 holds dword bits 31:24, lane 2 bits 23:16
   function automatic logic [15:0] w1c_mask(input logic [3:2] be_n, input logic [31:16] wd);
      logic [15:0] m;
      m = 16'h0000;
      if (!be_n[3]) begin
         m[15:8] = wd[31:24];
      end
      if (!be_n[2]) begin
         m[7:0] = wd[23:16];
      end
      return m;
   endfunction

   assign status_sel = (cfg_dw_addr == STATUS_DWORD);
   assign clr_mask = (cfg_wr && status_sel) ? w1c_mask(cfg_be_n, cfg_wdata) : 16'h0000;

   // observed perr pin, filtered before edge detection
   pin_filter u_perr_filter (
      .mclk(mclk),
      .rst_n(rst_n),
      .pin_in(perr_n_in),
      .level_q(perr_lvl)
   );

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         perr_prev_q <= PIN_IDLE;
      end else begin
         perr_prev_q <= perr_lvl;
      end
   end

   assign perr_seen = perr_prev_q && !perr_lvl;
   assign mdpe_set = (perr_self || perr_seen) && master_of_op && cmd_perr_resp;

   // system error pin driver, one cycle low per accepted request
   assign serr_fire = serr_req && cmd_serr_en;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         serr_state_q <= SERR_IDLE;
         serr_n_o_q <= PIN_IDLE;
         serr_oe_n_q <= PIN_IDLE;
      end else begin
         case (serr_state_q)
            SERR_IDLE: begin
               if (serr_fire) begin
                  serr_state_q <= SERR_DRIVE;
                  serr_n_o_q <= 1'b0;
                  serr_oe_n_q <= 1'b0;
               end
            end
            SERR_DRIVE: begin
               // open drain: release rather than drive high
               serr_state_q <= SERR_IDLE;
               serr_n_o_q <= PIN_IDLE;
               serr_oe_n_q <= PIN_IDLE;
            end
            default: begin
               serr_state_q <= SERR_IDLE;
               serr_n_o_q <= PIN_IDLE;
               serr_oe_n_q <= PIN_IDLE;
            end
         endcase
      end
   end

   // sticky flags: a set in the clearing cycle wins over the clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dpe_q <= STICKY_RESET;
      end else begin
         dpe_q <= (dpe_q && !clr_mask[DPE_BIT]) || parity_err_det;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sse_q <= STICKY_RESET;
      end else begin
         // only a request that really drives the pin may set the flag
         sse_q <= (sse_q && !clr_mask[SSE_BIT]) || (serr_fire && serr_state_q == SERR_IDLE);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rma_q <= STICKY_RESET;
      end else begin
         rma_q <= (rma_q && !clr_mask[RMA_BIT]) || master_abort;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rta_q <= STICKY_RESET;
      end else begin
         rta_q <= (rta_q && !clr_mask[RTA_BIT]) || target_abort_rcvd;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mdpe_q <= STICKY_RESET;
      end else begin
         mdpe_q <= (mdpe_q && !clr_mask[MDPE_BIT]) || mdpe_set;
      end
   end

   // fixed fields ignore writes entirely
   always_comb begin
      status_word = 16'h0000;
      status_word[DPE_BIT] = dpe_q;
      status_word[SSE_BIT] = sse_q;
      status_word[RMA_BIT] = rma_q;
      status_word[RTA_BIT] = rta_q;
      status_word[STA_BIT] = STA_VALUE;
      status_word[DEVSEL_LSB +: 2] = DEVSEL_MEDIUM;
      status_word[MDPE_BIT] = mdpe_q;
      status_word[FBB_BIT] = FBB_VALUE;
      status_word[CAPL_BIT] = eeprom_pm_en;
   end

   // read data captured at the status dword read strobe, held until the next status dword read
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rdata_q <= RDATA_RESET;
      end else if (cfg_rd && status_sel) begin
         cfg_rdata_q <= status_word;
      end
   end

   // capability pointer tracks the eeprom bit a cycle late
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cap_list_q <= 1'b0;
         cap_ptr_q <= CAP_PTR_NONE;
      end else begin
         cap_list_q <= eeprom_pm_en;
         cap_ptr_q <= eeprom_pm_en ? CAP_PTR_OFFSET : CAP_PTR_NONE;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_status_read;
      cfg_rd && status_sel;
   endsequence

   sequence s_dpe_clear_only;
      cfg_wr && status_sel && !cfg_be_n[3] && cfg_wdata[31] && !parity_err_det;
   endsequence

   property p_dpe_set;
      parity_err_det |=> dpe_q;
   endproperty
   a_dpe_set: assert property (p_dpe_set) else $error("parity error did not set bit 31");

   property p_dpe_w1c;
      s_dpe_clear_only |=> !dpe_q;
   endproperty
   a_dpe_w1c: assert property (p_dpe_w1c) else $error("write one did not clear bit 31");

   property p_dpe_hold;
      dpe_q && !(cfg_wr && status_sel && !cfg_be_n[3] && cfg_wdata[31]) |=> dpe_q;
   endproperty
   a_dpe_hold: assert property (p_dpe_hold) else $error("bit 31 lost without a one write");

   property p_sse_with_pin;
      !serr_oe_n_q |-> sse_q && !serr_n_o_q;
   endproperty
   a_sse_with_pin: assert property (p_sse_with_pin) else $error("pin driven but bit 30 clear");

   property p_serr_gated;
      serr_req && !cmd_serr_en && serr_oe_n_q |=> serr_oe_n_q;
   endproperty
   a_serr_gated: assert property (p_serr_gated) else $error("system error driven while disabled");

   property p_serr_pulse;
      serr_fire && serr_oe_n_q |=> !serr_oe_n_q ##1 serr_oe_n_q;
   endproperty
   a_serr_pulse: assert property (p_serr_pulse) else $error("system error pulse not one cycle");

   property p_rma_set;
      master_abort |=> rma_q;
   endproperty
   a_rma_set: assert property (p_rma_set) else $error("master abort did not set bit 29");

   property p_rta_set;
      target_abort_rcvd |=> rta_q;
   endproperty
   a_rta_set: assert property (p_rta_set) else $error("target abort did not set bit 28");

   property p_mdpe_cause;
      !mdpe_q ##1 mdpe_q |-> $past(mdpe_set);
   endproperty
   a_mdpe_cause: assert property (p_mdpe_cause) else $error("bit 24 set without all three causes");

   property p_mdpe_no_resp;
      !mdpe_q && !cmd_perr_resp |=> !mdpe_q;
   endproperty
   a_mdpe_no_resp: assert property (p_mdpe_no_resp) else $error("bit 24 set with response off");

   property p_fixed_fields;
      s_status_read |=> cfg_rdata_q[STA_BIT] == 1'b0 && cfg_rdata_q[DEVSEL_LSB +: 2] == 2'h1
         && cfg_rdata_q[FBB_BIT] && cfg_rdata_q[6:5] == 2'h0 && cfg_rdata_q[3:0] == 4'h0;
   endproperty
   a_fixed_fields: assert property (p_fixed_fields) else $error("fixed status fields wrong");

   property p_cap_bit_read;
      s_status_read |=> cfg_rdata_q[CAPL_BIT] == $past(eeprom_pm_en);
   endproperty
   a_cap_bit_read: assert property (p_cap_bit_read) else $error("bit 20 not following eeprom");

   property p_cap_ptr;
      eeprom_pm_en |=> cap_list_q && cap_ptr_q == CAP_PTR_OFFSET;
   endproperty
   a_cap_ptr: assert property (p_cap_ptr) else $error("capability offset missing");

   property p_read_data_holds;
      !(cfg_rd && status_sel) |=> $stable(cfg_rdata_q);
   endproperty
   a_read_data_holds: assert property (p_read_data_holds) else $error("read data changed without read");

   property p_sse_set;
      serr_fire && serr_oe_n_q |=> sse_q;
   endproperty
   a_sse_set: assert property (p_sse_set) else $error("system error did not set bit 30");

   property p_rma_w1c;
      cfg_wr && status_sel && !cfg_be_n[3] && cfg_wdata[29] && !master_abort |=> !rma_q;
   endproperty
   a_rma_w1c: assert property (p_rma_w1c) else $error("write one did not clear bit 29");

   property p_rta_w1c;
      cfg_wr && status_sel && !cfg_be_n[3] && cfg_wdata[28] && !target_abort_rcvd |=> !rta_q;
   endproperty
   a_rta_w1c: assert property (p_rta_w1c) else $error("write one did not clear bit 28");

   property p_mdpe_w1c;
      cfg_wr && status_sel && !cfg_be_n[3] && cfg_wdata[24] && !mdpe_set |=> !mdpe_q;
   endproperty
   a_mdpe_w1c: assert property (p_mdpe_w1c) else $error("write one did not clear bit 24");

   property p_cap_none;
      !eeprom_pm_en |=> !cap_list_q && cap_ptr_q == CAP_PTR_NONE;
   endproperty
   a_cap_none: assert property (p_cap_none) else $error("capability list shown without eeprom bit");
endmodule

// ---- sim/host_model.sv ----
// host side bus wires: pulled-up perr and serr lines
`timescale 1ns/1ps
module host_model (
   input wire logic perr_drive,
   input wire logic serr_n_o_q,
   input wire logic serr_oe_n_q,
   output logic perr_n,
   output logic serr_wire
);
   // both lines idle high through the pull-up when nobody drives
   assign perr_n = perr_drive ? 1'b0 : 1'b1;
   assign serr_wire = serr_oe_n_q ? 1'b1 : serr_n_o_q;
endmodule

// ---- sim/test_bus_status_regs.sv ----
// testbench for the bus event status half-dword
`timescale 1ns/1ps
module test_bus_status_regs;
   import bus_status_pkg::*;
   logic mclk, rst_n, wr, rd, perr_resp, serr_en, mop, pm, perr_drive, perr_n, serr_wire;
   logic [5:0] addr;
   logic [1:0] ben;
   logic [15:0] wd, rdata;
   logic [4:0] ev;
   logic [7:0] cap_ptr;
   logic cap_list, serr_n_o, serr_oe_n;
   int num_errors, checked;
   bus_status_regs dut (.mclk(mclk), .rst_n(rst_n), .cfg_wr(wr), .cfg_rd(rd), .cfg_dw_addr(addr),
      .cfg_be_n(ben), .cfg_wdata(wd), .cmd_perr_resp(perr_resp), .cmd_serr_en(serr_en),
      .parity_err_det(ev[4]), .serr_req(ev[3]), .master_abort(ev[2]), .target_abort_rcvd(ev[1]),
      .perr_self(ev[0]), .master_of_op(mop), .perr_n_in(perr_n), .eeprom_pm_en(pm),
      .cfg_rdata_q(rdata), .cap_ptr_q(cap_ptr), .cap_list_q(cap_list), .serr_n_o_q(serr_n_o),
      .serr_oe_n_q(serr_oe_n));
   host_model host (.perr_drive(perr_drive), .serr_n_o_q(serr_n_o), .serr_oe_n_q(serr_oe_n),
      .perr_n(perr_n), .serr_wire(serr_wire));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task close_out;
      if (num_errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one config cycle; strobes low again before the next call
   task cfg(input logic w, input logic r, input logic [5:0] a, input logic [1:0] b, input logic [15:0] d);
      @(negedge mclk);
      wr = w;
      rd = r;
      addr = a;
      ben = b;
      wd = d;
      @(negedge mclk);
      wr = 1'b0;
      rd = 1'b0;
   endtask
   task rd_chk(input logic [15:0] exp);
      cfg(1'b0, 1'b1, STATUS_DWORD, 2'h3, 16'h0000);
      check("status", rdata, exp);
   endtask
   task clr(input logic [15:0] d);
      cfg(1'b1, 1'b0, STATUS_DWORD, 2'h0, d);
   endtask
   task fire(input logic [4:0] v);
      @(negedge mclk);
      ev = v;
      @(negedge mclk);
      ev = 5'h00;
   endtask
   initial begin
      #20000;
      num_errors++;
      close_out();
   end
   initial begin
      {wr, rd, perr_resp, serr_en, mop, pm, perr_drive} = 7'h00;
      addr = 6'h00;
      ben = 2'h3;
      wd = 16'h0000;
      ev = 5'h00;
      num_errors = 0;
      checked = 0;
      rst_n = 1'b0;
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      // fixed fields: devsel medium, fast back-to-back one, rest zero
      rd_chk(16'h0280);
      check("cap_ptr", {8'h00, cap_ptr}, 16'h0000);
      pm = 1'b1;
      rd_chk(16'h0290);
      check("cap_ptr", {8'h00, cap_ptr}, 16'h00DC);
      check("cap_list", {15'h0000, cap_list}, 16'h0001);
      pm = 1'b0;
      rd_chk(16'h0280);
      check("cap_ptr", {8'h00, cap_ptr}, 16'h0000);
      check("cap_list", {15'h0000, cap_list}, 16'h0000);
      // parity error counts even with response disabled
      fire(5'h10);
      rd_chk(16'h8280);
      clr(16'h0000);
      cfg(1'b1, 1'b0, STATUS_DWORD, 2'h2, 16'hFFFF);
      cfg(1'b1, 1'b0, 6'h02, 2'h0, 16'hFFFF);
      rd_chk(16'h8280);
      cfg(1'b1, 1'b0, 6'h02, 2'h0, 16'h0000);
      cfg(1'b0, 1'b1, 6'h02, 2'h3, 16'h0000);
      check("rdata_hold", rdata, 16'h8280);
      // set wins over a write-one in the same cycle
      @(negedge mclk);
      ev = 5'h10;
      cfg(1'b1, 1'b0, STATUS_DWORD, 2'h0, 16'h8000);
      ev = 5'h00;
      rd_chk(16'h8280);
      clr(16'hFFFF);
      rd_chk(16'h0280);
      // system error refused while disabled
      fire(5'h08);
      check("serr_oe_n", {15'h0000, serr_oe_n}, 16'h0001);
      rd_chk(16'h0280);
      serr_en = 1'b1;
      fire(5'h08);
      check("serr_wire", {15'h0000, serr_wire}, 16'h0000);
      @(negedge mclk);
      check("serr_oe_n", {15'h0000, serr_oe_n}, 16'h0001);
      rd_chk(16'h4280);
      clr(16'h4000);
      fire(5'h06);
      rd_chk(16'h3280);
      clr(16'h1000);
      rd_chk(16'h2280);
      clr(16'h2000);
      rd_chk(16'h0280);
      // bit 24 needs all three conditions together
      mop = 1'b1;
      fire(5'h01);
      rd_chk(16'h0280);
      perr_resp = 1'b1;
      mop = 1'b0;
      fire(5'h01);
      rd_chk(16'h0280);
      mop = 1'b1;
      fire(5'h01);
      rd_chk(16'h0380);
      clr(16'h0100);
      rd_chk(16'h0280);
      // pin path goes through the filter, so hold it low a while
      perr_drive = 1'b1;
      repeat (8) @(negedge mclk);
      perr_drive = 1'b0;
      rd_chk(16'h0380);
      clr(16'h0100);
      rd_chk(16'h0280);
      // every flag set, then a mid-run reset must bring them all back to zero
      fire(5'h1F);
      rd_chk(16'hF380);
      @(negedge mclk);
      rst_n = 1'b0;
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      rd_chk(16'h0280);
      check("serr_oe_n", {15'h0000, serr_oe_n}, 16'h0001);
      close_out();
   end
endmodule
